// ==== hw/dbgtrg_pkg.sv ====
// Function
// RQ1: source select: any access, or executed opcode
// RQ2: capture position: end at trigger or begin
// RQ3: reserved config and status bits read zero
// RQ4: modes 0-4: A, A|B, A>B, evtB, A>evtB
// RQ5: modes 5-8 and, and-not, inside, outside
// RQ6: status bit 7 shows A since arming
// RQ7: status bit 6 shows B since arming
// RQ8: status bit 5 shows C since arming
// RQ9: status bit 0 mirrors arm while enabled
// RQ10: end-run reset clears armed flag
// RQ11: end-trace reset keeps hits, clears armed; code keeps hits only in enabled end-at-trigger runs
// RQ12: config writes ignored while armed
// RQ13: arm bit gates comparing and storing
// RQ14: arming clears the three hit flags
package dbgtrg_pkg;
   // =======================================
   // register map (byte addresses)
   localparam logic [7:0] OFF_TRIG_CFG = 8'h00;
   localparam logic [7:0] OFF_STATUS   = 8'h04;
   localparam logic [7:0] OFF_CTRL     = 8'h08;
   localparam logic [7:0] OFF_IRQ_STAT = 8'h0C;
   localparam logic [7:0] OFF_IRQ_MASK = 8'h10;
   // =======================================
   // field positions
   localparam int CFG_SRC_SEL_BIT = 7;
   localparam int CFG_BEGIN_BIT   = 6;
   localparam int ST_A_BIT        = 7;
   localparam int ST_B_BIT        = 6;
   localparam int ST_C_BIT        = 5;
   localparam int ST_ARMED_BIT    = 0;
   localparam int CTRL_EN_BIT     = 7;
   localparam int CTRL_ARM_BIT    = 6;
   localparam int IRQ_TRIG_BIT    = 0;
   localparam int IRQ_DONE_BIT    = 1;
   localparam logic [7:0] CFG_WR_MASK  = 8'hCF;
   localparam logic [7:0] CTRL_WR_MASK = 8'hC0;
   localparam logic [7:0] IRQ_WR_MASK  = 8'h03;
   // =======================================
   // values after reset
   localparam logic [7:0] CFG_RESET  = 8'h00;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [7:0] IRQ_RESET  = 8'h00;
   // =======================================
   // trigger modes
   localparam logic [3:0] MODE_A_ONLY     = 4'h0;
   localparam logic [3:0] MODE_A_OR_B     = 4'h1;
   localparam logic [3:0] MODE_A_THEN_B   = 4'h2;
   localparam logic [3:0] MODE_EVT_B      = 4'h3;
   localparam logic [3:0] MODE_A_THEN_EVB = 4'h4;
   localparam logic [3:0] MODE_A_AND_B    = 4'h5;
   localparam logic [3:0] MODE_A_NOT_B    = 4'h6;
   localparam logic [3:0] MODE_INSIDE     = 4'h7;
   localparam logic [3:0] MODE_OUTSIDE    = 4'h8;
   // =======================================
   // bus answers
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // =======================================
   // monitored core bus, one cycle per access
   typedef struct packed {
      logic access;   // an access took place this cycle
      logic exec;     // opcode at the address was executed
      logic a_hit;    // address equals comparator A
      logic b_hit;    // address equals comparator B
      logic c_hit;    // address equals comparator C
      logic in_range; // address between A and B
   } dbgtrg_core_t;
endpackage

// ==== hw/dbgtrg_top.sv ====
`timescale 1ns/1ps
module dbgtrg_top #(
   parameter int ADDR_W = 8
) (
   input  wire logic                      clk,             // 250 MHz system clock
   input  wire logic                      reset_n,         // synchronous power-on reset
   input  wire logic                      end_run_rst,     // end-run reset pulse
   input  wire logic                      end_trace_rst,   // end-trace reset pulse
   input  wire dbgtrg_pkg::dbgtrg_core_t  core,            // comparator results per access
   input  wire logic                      fifo_full,       // trace fifo reached its depth
   output logic                           trigger_out,     // one-cycle trigger pulse
   output logic                           store_out,       // store current access in fifo
   output logic                           armed_out,       // armed state to fifo and count
   output logic                           trace_done,      // one-cycle end of trace run
   output logic                           irq,             // level interrupt
   input  wire logic [ADDR_W-1:0]         s_axi_awaddr,    // write address
   input  wire logic                      s_axi_awvalid,   // write address valid
   output logic                           s_axi_awready,   // write address ready
   input  wire logic [31:0]               s_axi_wdata,     // write data
   input  wire logic [3:0]                s_axi_wstrb,     // write strobes
   input  wire logic                      s_axi_wvalid,    // write data valid
   output logic                           s_axi_wready,    // write data ready
   output logic [1:0]                     s_axi_bresp,     // write response
   output logic                           s_axi_bvalid,    // write response valid
   input  wire logic                      s_axi_bready,    // write response ready
   input  wire logic [ADDR_W-1:0]         s_axi_araddr,    // read address
   input  wire logic                      s_axi_arvalid,   // read address valid
   output logic                           s_axi_arready,   // read address ready
   output logic [31:0]                    s_axi_rdata,     // read data
   output logic [1:0]                     s_axi_rresp,     // read response
   output logic                           s_axi_rvalid,    // read data valid
   input  wire logic                      s_axi_rready     // read data ready
);

   if (ADDR_W < 5 || ADDR_W > 8) begin : g_chk
      $error("dbgtrg_top: ADDR_W must lie in 5..8");
   end

   typedef enum logic [1:0] {CAP_IDLE, CAP_WAIT, CAP_STORE} dbgtrg_cap_t;

   // =======================================
   // registers
   logic [7:0]  cfg_reg;
   logic [7:0]  ctrl_reg;
   logic [7:0]  irq_stat_reg;
   logic [7:0]  irq_mask_reg;
   logic        a_flag_reg;
   logic        b_flag_reg;
   logic        c_flag_reg;
   logic        a_seen_reg;
   logic        arm_prev_reg;
   dbgtrg_cap_t cap_reg;
   logic [ADDR_W-1:0] aw_addr_reg;
   logic [31:0] w_data_reg;
   logic [3:0]  w_strb_reg;
   logic        aw_have_reg;
   logic        w_have_reg;

   logic        en;
   logic        arm;
   logic        begin_mode;
   logic        armed;
   logic        arm_rise;
   logic        keep_trace;
   logic        soft_por;
   logic        wr_go;
   logic        wr_lane0;
   logic [7:0]  wr_byte;
   logic [7:0]  wr_off;
   logic [7:0]  rd_off;
   logic        qual;
   logic        hit_a;
   logic        hit_b;
   logic        hit_c;
   logic        hit_rng;
   logic        fire;
   logic        evt_only;
   logic        hw_disarm;
   logic [7:0]  status_val;

   assign en         = ctrl_reg[dbgtrg_pkg::CTRL_EN_BIT];
   assign arm        = ctrl_reg[dbgtrg_pkg::CTRL_ARM_BIT];
   assign begin_mode = cfg_reg[dbgtrg_pkg::CFG_BEGIN_BIT];
   assign armed      = en & arm;                                             // RQ13
   assign arm_rise   = armed & ~arm_prev_reg;
   // an end-trace reset only preserves state in end-at-trigger runs
   assign keep_trace = end_trace_rst & en & ~begin_mode;                     // RQ11
   assign soft_por   = end_trace_rst & ~keep_trace;

   // =======================================
   // axi4-lite write path
   assign wr_go    = aw_have_reg & w_have_reg & ~s_axi_bvalid;
   assign wr_off   = 8'(aw_addr_reg);
   assign wr_byte  = w_data_reg[7:0];
   assign wr_lane0 = wr_go & w_strb_reg[0];

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         aw_have_reg   <= 1'b0;
         aw_addr_reg   <= '0;
         s_axi_awready <= 1'b0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_have_reg   <= 1'b1;
         aw_addr_reg   <= s_axi_awaddr;
         s_axi_awready <= 1'b0;
      end else if (wr_go) begin
         aw_have_reg   <= 1'b0;
      end else begin
         s_axi_awready <= ~aw_have_reg & ~s_axi_bvalid;
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         w_have_reg   <= 1'b0;
         w_data_reg   <= '0;
         w_strb_reg   <= '0;
         s_axi_wready <= 1'b0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_have_reg   <= 1'b1;
         w_data_reg   <= s_axi_wdata;
         w_strb_reg   <= s_axi_wstrb;
         s_axi_wready <= 1'b0;
      end else if (wr_go) begin
         w_have_reg   <= 1'b0;
      end else begin
         s_axi_wready <= ~w_have_reg & ~s_axi_bvalid;
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= dbgtrg_pkg::RESP_OKAY;
      end else if (wr_go) begin
         s_axi_bvalid <= 1'b1;
         unique case (wr_off)
            dbgtrg_pkg::OFF_TRIG_CFG, dbgtrg_pkg::OFF_STATUS, dbgtrg_pkg::OFF_CTRL,
            dbgtrg_pkg::OFF_IRQ_STAT, dbgtrg_pkg::OFF_IRQ_MASK:
               s_axi_bresp <= dbgtrg_pkg::RESP_OKAY;
            default:
               s_axi_bresp <= dbgtrg_pkg::RESP_SLVERR;
         endcase
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // =======================================
   // axi4-lite read path
   assign status_val = {a_flag_reg, b_flag_reg, c_flag_reg, 4'h0,            // RQ3
                        armed};                                              // RQ9
   assign rd_off     = 8'(s_axi_araddr);

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= '0;
         s_axi_rresp   <= dbgtrg_pkg::RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rresp   <= dbgtrg_pkg::RESP_OKAY;
         unique case (rd_off)
            dbgtrg_pkg::OFF_TRIG_CFG: s_axi_rdata <= {24'h0, cfg_reg};
            dbgtrg_pkg::OFF_STATUS:   s_axi_rdata <= {24'h0, status_val};     // RQ6 RQ7 RQ8
            dbgtrg_pkg::OFF_CTRL:     s_axi_rdata <= {24'h0, ctrl_reg};
            dbgtrg_pkg::OFF_IRQ_STAT: s_axi_rdata <= {24'h0, irq_stat_reg};
            dbgtrg_pkg::OFF_IRQ_MASK: s_axi_rdata <= {24'h0, irq_mask_reg};
            default: begin
               s_axi_rdata <= '0;
               s_axi_rresp <= dbgtrg_pkg::RESP_SLVERR;
            end
         endcase
      end else if (s_axi_rvalid) begin
         s_axi_rvalid <= ~s_axi_rready;
      end else begin
         s_axi_arready <= 1'b1;
      end
   end

   // =======================================
   // trigger configuration
   always_ff @(posedge clk) begin
      if (!reset_n || soft_por) begin
         cfg_reg <= dbgtrg_pkg::CFG_RESET;
      end else if (wr_lane0 && wr_off == dbgtrg_pkg::OFF_TRIG_CFG && !arm) begin // RQ12
         cfg_reg <= wr_byte & dbgtrg_pkg::CFG_WR_MASK;                     // RQ3
      end
   end

   // =======================================
   // control: enable and arm
   always_ff @(posedge clk) begin
      if (!reset_n || soft_por) begin
         ctrl_reg <= dbgtrg_pkg::CTRL_RESET;
      end else if (end_run_rst || keep_trace || hw_disarm) begin
         ctrl_reg[dbgtrg_pkg::CTRL_ARM_BIT] <= 1'b0;                       // RQ10 RQ11
      end else if (wr_lane0 && wr_off == dbgtrg_pkg::OFF_CTRL) begin
         ctrl_reg <= wr_byte & dbgtrg_pkg::CTRL_WR_MASK;
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         arm_prev_reg <= 1'b0;
      end else begin
         arm_prev_reg <= armed;
      end
   end

   // =======================================
   // qualified comparator hits
   assign qual    = cfg_reg[dbgtrg_pkg::CFG_SRC_SEL_BIT] ? core.exec : core.access; // RQ1
   assign hit_a   = core.a_hit & qual;
   assign hit_b   = core.b_hit & qual;
   assign hit_c   = core.c_hit & qual;
   assign hit_rng = core.in_range & qual;

   always_comb begin
      fire     = 1'b0;
      evt_only = 1'b0;
      unique case (cfg_reg[3:0])
         dbgtrg_pkg::MODE_A_ONLY:     fire = hit_a;                         // RQ4
         dbgtrg_pkg::MODE_A_OR_B:     fire = hit_a | hit_b;                 // RQ4
         dbgtrg_pkg::MODE_A_THEN_B:   fire = a_seen_reg & hit_b;            // RQ4
         dbgtrg_pkg::MODE_EVT_B: begin
            fire     = hit_b;                                               // RQ4
            evt_only = 1'b1;
         end
         dbgtrg_pkg::MODE_A_THEN_EVB: begin
            fire     = a_seen_reg & hit_b;                                  // RQ4
            evt_only = 1'b1;
         end
         dbgtrg_pkg::MODE_A_AND_B:    fire = hit_a & hit_b;                 // RQ5
         dbgtrg_pkg::MODE_A_NOT_B:    fire = hit_a & ~hit_b;                // RQ5
         dbgtrg_pkg::MODE_INSIDE:     fire = hit_rng;                       // RQ5
         dbgtrg_pkg::MODE_OUTSIDE:    fire = qual & ~core.in_range;         // RQ5
         default:                     fire = 1'b0;                          // RQ5
      endcase
   end

   // the "then" modes need A seen strictly before the B access
   always_ff @(posedge clk) begin
      if (!reset_n || arm_rise) begin
         a_seen_reg <= 1'b0;
      end else if (armed && hit_a) begin
         a_seen_reg <= 1'b1;
      end
   end

   // =======================================
   // match flags since arming
   // end-run reset leaves them as they were; undefined there anyway
   always_ff @(posedge clk) begin
      if (!reset_n || soft_por) begin
         a_flag_reg <= 1'b0;
         b_flag_reg <= 1'b0;
         c_flag_reg <= 1'b0;
      end else if (armed) begin
         // a hit in the arming cycle still counts, so set beats clear
         a_flag_reg <= hit_a | (a_flag_reg & ~arm_rise);                    // RQ6 RQ14
         b_flag_reg <= hit_b | (b_flag_reg & ~arm_rise);                    // RQ7 RQ14
         c_flag_reg <= hit_c | (c_flag_reg & ~arm_rise);                    // RQ8 RQ14
      end
   end

   // =======================================
   // capture sequencing
   always_comb begin
      hw_disarm = 1'b0;
      if (armed && !arm_rise && cap_reg == CAP_STORE) begin
         hw_disarm = begin_mode ? fifo_full : fire;                         // RQ2
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n || !armed) begin
         cap_reg <= CAP_IDLE;
      end else if (arm_rise) begin
         cap_reg <= begin_mode ? CAP_WAIT : CAP_STORE;                      // RQ2
      end else begin
         unique case (cap_reg)
            CAP_IDLE:  cap_reg <= CAP_IDLE;
            CAP_WAIT:  cap_reg <= fire ? CAP_STORE : CAP_WAIT;              // RQ2
            CAP_STORE: cap_reg <= hw_disarm ? CAP_IDLE : CAP_STORE;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         trigger_out <= 1'b0;
         store_out   <= 1'b0;
         armed_out   <= 1'b0;
         trace_done  <= 1'b0;
      end else begin
         trigger_out <= armed & ~arm_rise & fire & (cap_reg != CAP_IDLE);    // RQ13
         // event-only modes store just the B accesses
         store_out   <= armed & (cap_reg == CAP_STORE)
                        & (evt_only ? hit_b : qual);                        // RQ13
         armed_out   <= armed;
         trace_done  <= hw_disarm;
      end
   end

   // =======================================
   // interrupts: sticky, write one to clear, set wins
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         irq_stat_reg <= dbgtrg_pkg::IRQ_RESET;
      end else begin
         if (wr_lane0 && wr_off == dbgtrg_pkg::OFF_IRQ_STAT) begin
            irq_stat_reg <= irq_stat_reg & ~wr_byte;
         end
         if (armed && !arm_rise && fire && cap_reg != CAP_IDLE) begin
            irq_stat_reg[dbgtrg_pkg::IRQ_TRIG_BIT] <= 1'b1;
         end
         if (hw_disarm) begin
            irq_stat_reg[dbgtrg_pkg::IRQ_DONE_BIT] <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         irq_mask_reg <= dbgtrg_pkg::IRQ_RESET;
      end else if (wr_lane0 && wr_off == dbgtrg_pkg::OFF_IRQ_MASK) begin
         irq_mask_reg <= wr_byte & dbgtrg_pkg::IRQ_WR_MASK;
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         irq <= 1'b0;
      end else begin
         irq <= |(irq_stat_reg & irq_mask_reg);
      end
   end

endmodule

// ==== tb/dbgtrg_checker.sv ====
`timescale 1ns/1ps
module dbgtrg_checker (
   input wire logic        clk,           // clock
   input wire logic        reset_n,       // reset
   input wire logic        end_run_rst,   // end-run reset
   input wire logic        trigger_out,   // trigger
   input wire logic        store_out,     // store
   input wire logic        armed_out,     // armed
   input wire logic        trace_done,    // run ended
   input wire logic        irq,           // interrupt
   input wire logic        s_axi_awvalid, // aw valid
   input wire logic        s_axi_awready, // aw ready
   input wire logic        s_axi_wvalid,  // w valid
   input wire logic        s_axi_wready,  // w ready
   input wire logic [1:0]  s_axi_bresp,   // b resp
   input wire logic        s_axi_bvalid,  // b valid
   input wire logic        s_axi_bready,  // b ready
   input wire logic        s_axi_arvalid, // ar valid
   input wire logic        s_axi_arready, // ar ready
   input wire logic [31:0] s_axi_rdata,   // r data
   input wire logic [1:0]  s_axi_rresp,   // r resp
   input wire logic        s_axi_rvalid,  // r valid
   input wire logic        s_axi_rready   // r ready
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   // =====================================
   // steps of a bus transfer
   sequence s_ar_taken;
      s_axi_arvalid && s_axi_arready;
   endsequence
   sequence s_wr_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   // =====================================
   // properties
   property p_store_armed;
      store_out |-> armed_out;
   endproperty
   property p_trig_armed;
      trigger_out |-> armed_out;
   endproperty
   property p_done_pulse;
      trace_done |=> !trace_done;
   endproperty
   property p_done_disarm;
      trace_done |-> ##[0:2] !armed_out;
   endproperty
   property p_end_run;
      end_run_rst |-> ##2 !armed_out;
   endproperty
   property p_rd_reserved;
      s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000;
   endproperty
   property p_rd_answer;
      s_ar_taken |=> s_axi_rvalid;
   endproperty
   property p_wr_answer;
      s_wr_taken |-> ##[1:2] s_axi_bvalid;
   endproperty
   property p_rd_hold;
      s_axi_rvalid && !s_axi_rready |=>
         s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp);
   endproperty
   property p_wr_hold;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   // reset silences every answer by the next edge
   property p_reset_quiet;
      disable iff (1'b0) !reset_n |=> !s_axi_rvalid && !s_axi_bvalid && !armed_out && !irq;
   endproperty
   a_store_armed: assert property (p_store_armed) else $error("store while not armed");
   a_trig_armed: assert property (p_trig_armed) else $error("trigger while not armed");
   a_done_pulse: assert property (p_done_pulse) else $error("done longer than one cycle");
   a_done_disarm: assert property (p_done_disarm) else $error("still armed after done");
   a_end_run: assert property (p_end_run) else $error("armed after end-run reset");
   a_rd_reserved: assert property (p_rd_reserved) else $error("upper read bits set");
   a_rd_answer: assert property (p_rd_answer) else $error("read answer late");
   a_wr_answer: assert property (p_wr_answer) else $error("write answer late");
   a_rd_hold: assert property (p_rd_hold) else $error("read answer changed");
   a_wr_hold: assert property (p_wr_hold) else $error("write answer changed");
   a_reset_quiet: assert property (p_reset_quiet) else $error("outputs active in reset");
endmodule
bind dbgtrg_top dbgtrg_checker i_dbgtrg_checker (
   .clk, .reset_n, .end_run_rst, .trigger_out, .store_out, .armed_out, .trace_done, .irq,
   .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
   .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
   .s_axi_rready
);

// ==== tb/dbgtrg_core_model.sv ====
`timescale 1ns/1ps
module dbgtrg_core_model (
   input  wire logic               clk,  // system clock
   output dbgtrg_pkg::dbgtrg_core_t core  // one access per cycle
);
   initial core = '0;
   // idle cycles let the bench play a slow or a prompt core
   task automatic issue(input dbgtrg_pkg::dbgtrg_core_t c, input int idle);
      c.access = c.access | c.exec;
      repeat (idle) @(posedge clk);
      @(posedge clk);
      core <= c;
      @(posedge clk);
      core <= '0;
   endtask
endmodule

// ==== tb/testbench.sv ====
`timescale 1ns/1ps
`define CHK(n, e, g) begin checked++; if ((e) !== (g)) mismatch(n, e, g); end
module testbench;
   // =====================================
   // signals
   logic                     clk           = 1'b0;
   logic                     reset_n       = 1'b0;
   logic                     end_run_rst   = 1'b0;
   logic                     end_trace_rst = 1'b0;
   logic                     fifo_full     = 1'b0;
   logic [7:0]               s_axi_awaddr  = 8'h00;
   logic [7:0]               s_axi_araddr  = 8'h00;
   logic [31:0]              s_axi_wdata   = 32'h00000000;
   logic [3:0]               s_axi_wstrb   = 4'h0;
   logic                     s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic                     s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic                     s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic                     s_axi_rvalid, trigger_out, store_out, armed_out, trace_done, irq;
   logic [1:0]               s_axi_bresp, s_axi_rresp;
   logic [31:0]              s_axi_rdata;
   dbgtrg_pkg::dbgtrg_core_t core;
   logic [33:0]              exp_q[$];
   logic [33:0]              exp_now;
   int                       err_count = 0, checked = 0, trig_n = 0, done_n = 0, store_n = 0;
   int                       s0, d0;
   int                       seed = 32'hAA413C77;
   // per mode: b then a outside range, a with b inside
   localparam logic [15:0]   TRIG_X = 16'h014B;
   localparam logic [15:0]   TRIG_Y = 16'h00AB;
   always #2 clk = ~clk;
   dbgtrg_top #(.ADDR_W(8)) i_dbgtrg_top (
      .clk, .reset_n, .end_run_rst, .end_trace_rst, .core, .fifo_full, .trigger_out,
      .store_out, .armed_out, .trace_done, .irq, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready
   );
   dbgtrg_core_model i_dbgtrg_core_model (.clk, .core);
   // =====================================
   // monitor
   always @(posedge clk) begin
      if (trigger_out) trig_n++;
      if (trace_done) done_n++;
      if (store_out) store_n++;
      if (s_axi_rvalid && s_axi_rready) begin
         exp_now = (exp_q.size() > 0) ? exp_q.pop_front() : 34'h3FFFFFFFF;
         `CHK("read answer", exp_now, {s_axi_rresp, s_axi_rdata})
      end
   end
   // =====================================
   // tasks
   task automatic mismatch(input string n, input logic [33:0] e, input logic [33:0] g);
      err_count++;
      $display("FAIL %s expected %h seen %h", n, e, g);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d,
                     input logic [1:0] r = dbgtrg_pkg::RESP_OKAY);
      logic [31:0] rnd;
      bit          aw_ok = 1'b0, w_ok = 1'b0;
      rnd = $random(seed);
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {rnd[31:8], d};
      s_axi_wstrb <= rnd[3:0] | 4'h1;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      while (!(aw_ok && w_ok)) begin
         @(posedge clk);
         if (s_axi_awready) aw_ok = 1'b1;
         if (s_axi_wready) w_ok = 1'b1;
         if (aw_ok) s_axi_awvalid <= 1'b0;
         if (w_ok) s_axi_wvalid <= 1'b0;
      end
      s_axi_bready <= 1'b1;
      do @(posedge clk); while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
      `CHK("write response", r, s_axi_bresp)
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] d,
                     input logic [1:0] r = dbgtrg_pkg::RESP_OKAY);
      @(posedge clk);
      exp_q.push_back({r, 24'h000000, d});
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do @(posedge clk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      s_axi_rready <= 1'b1;
      do @(posedge clk); while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 1'b0;
   endtask
   task automatic arm(input logic [7:0] cfg);
      wr(dbgtrg_pkg::OFF_CTRL, 8'h00);
      wr(dbgtrg_pkg::OFF_TRIG_CFG, cfg);
      wr(dbgtrg_pkg::OFF_CTRL, 8'hC0);
      s0 = store_n;
      d0 = done_n;
   endtask
   task automatic run(input logic [7:0] cfg, input logic [5:0] s1, input logic [5:0] s2,
                      input bit exp_t);
      int t0;
      arm(cfg);
      t0 = trig_n;
      i_dbgtrg_core_model.issue(s1, $random(seed) & 3);
      if (s2 != 6'h00) i_dbgtrg_core_model.issue(s2, $random(seed) & 3);
      repeat (4) @(posedge clk);
      `CHK("trigger count", exp_t, trig_n - t0)
      `CHK("done count", exp_t, done_n - d0)
   endtask
   task automatic final_report();
      $display("comparisons %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // =====================================
   // tests
   initial begin
      repeat (6) @(posedge clk);
      reset_n <= 1'b1;
      for (int a = 0; a < 20; a += 4) rd(8'(a), 8'h00);
      rd(8'h14, 8'h00, dbgtrg_pkg::RESP_SLVERR);
      wr(8'h14, 8'h5A, dbgtrg_pkg::RESP_SLVERR);
      wr(dbgtrg_pkg::OFF_STATUS, 8'hFF);
      rd(dbgtrg_pkg::OFF_STATUS, 8'h00);
      wr(dbgtrg_pkg::OFF_TRIG_CFG, 8'hFF);
      rd(dbgtrg_pkg::OFF_TRIG_CFG, 8'hCF);
      $display("test registers done");
      for (int m = 0; m < 16; m++) begin
         run(8'(m), 6'b100100, 6'b101000, TRIG_X[m]);
         run(8'(m), 6'b101101, 6'b000000, TRIG_Y[m]);
         `CHK("armed", !TRIG_Y[m], armed_out)
         rd(dbgtrg_pkg::OFF_STATUS, {7'h60, !TRIG_Y[m]});
         wr(dbgtrg_pkg::OFF_TRIG_CFG, 8'hFF);
         rd(dbgtrg_pkg::OFF_TRIG_CFG, TRIG_Y[m] ? 8'hCF : 8'(m));
      end
      $display("test modes done");
      run(8'h80, 6'b101000, 6'b000000, 1'b0);
      run(8'h80, 6'b111000, 6'b000000, 1'b1);
      $display("test source select done");
      arm(8'h40);
      i_dbgtrg_core_model.issue(6'b100000, 1);
      repeat (3) @(posedge clk);
      `CHK("store before trigger", 0, store_n - s0)
      i_dbgtrg_core_model.issue(6'b101000, 0);
      i_dbgtrg_core_model.issue(6'b100000, 0);
      i_dbgtrg_core_model.issue(6'b100000, 2);
      repeat (3) @(posedge clk);
      `CHK("stores after trigger", 2, store_n - s0)
      `CHK("armed while storing", 1'b1, armed_out)
      fifo_full <= 1'b1;
      repeat (2) @(posedge clk);
      fifo_full <= 1'b0;
      repeat (3) @(posedge clk);
      `CHK("done on full", 1, done_n - d0)
      `CHK("armed after full", 1'b0, armed_out)
      $display("test begin capture done");
      arm(8'h09);
      rd(dbgtrg_pkg::OFF_STATUS, 8'h01);
      i_dbgtrg_core_model.issue(6'b101010, 0);
      i_dbgtrg_core_model.issue(6'b100000, 3);
      repeat (3) @(posedge clk);
      `CHK("stores from arming", 2, store_n - s0)
      rd(dbgtrg_pkg::OFF_STATUS, 8'hA1);
      end_trace_rst <= 1'b1;
      @(posedge clk);
      end_trace_rst <= 1'b0;
      rd(dbgtrg_pkg::OFF_STATUS, 8'hA0);
      rd(dbgtrg_pkg::OFF_TRIG_CFG, 8'h09);
      wr(dbgtrg_pkg::OFF_CTRL, 8'hC0);
      rd(dbgtrg_pkg::OFF_STATUS, 8'h01);
      i_dbgtrg_core_model.issue(6'b100100, 0);
      rd(dbgtrg_pkg::OFF_STATUS, 8'h41);
      end_run_rst <= 1'b1;
      @(posedge clk);
      end_run_rst <= 1'b0;
      rd(dbgtrg_pkg::OFF_STATUS, 8'h40);
      $display("test resets done");
      rd(dbgtrg_pkg::OFF_IRQ_STAT, 8'h03);
      `CHK("irq masked", 1'b0, irq)
      wr(dbgtrg_pkg::OFF_IRQ_MASK, 8'h03);
      repeat (3) @(posedge clk);
      `CHK("irq raised", 1'b1, irq)
      wr(dbgtrg_pkg::OFF_IRQ_STAT, 8'h03);
      repeat (3) @(posedge clk);
      `CHK("irq cleared", 1'b0, irq)
      rd(dbgtrg_pkg::OFF_IRQ_STAT, 8'h00);
      $display("test interrupt done");
      repeat (4) @(posedge clk);
      final_report();
   end
   initial begin
      // roughly a thousand cycles needed, wide margin
      repeat (40000) @(posedge clk);
      err_count++;
      final_report();
   end
endmodule
